// ---- common/rxhop_pkg.sv ----
// Overview of operation
// - Synthesizer integer and fraction settings form base frequency, channel 0.
// - Step size is high and low parts; tune base plus channel times step.
// - Second argument byte of receive or transmit start is the channel number.
// - Start without channel reuses stored channel; stored channel resets to 0.
// - Hop table holds 64 channel entries; a size setting gives active count. Code writes only entries 0 to 31 over the bus.
// - With auto hop enabled, hopping starts on entering receive, no command needed.
// - Entries are visited first to last, wrapping to the first after the last.
// - Entries equal to 0xFF are skipped to the next usable entry.
// - RSSI, preamble and sync conditions enable separately; first resolved decides.
// - Instantaneous RSSI above threshold stays; below threshold hops onward.
// - Preamble and sync conditions need packet handling; raw mode uses RSSI only.
// - An automatic receive-to-receive hop completes within 115 microseconds.
// - Manual hop command retunes receive channel within 75 microseconds.
// - A general pin may toggle on every hop and on every table wrap; code leaves it unchanged on a hop that wraps.
// - Frequency is (integer plus fraction over 2^19) times 2 crystal over 8.
// - Hop decisions use RSSI as it is at the moment of evaluation.
package rxhop_pkg;

  localparam int CLK_MHZ         = 25;
  localparam int AUTO_HOP_US     = 115;
  localparam int MANUAL_HOP_US   = 75;
  // Longest times in clock cycles
  localparam int AUTO_HOP_CYC    = (AUTO_HOP_US * CLK_MHZ);
  localparam int MANUAL_HOP_CYC  = (MANUAL_HOP_US * CLK_MHZ);
  // Retune settle used by the synthesizer sequencer, well inside both bounds
  localparam logic [11:0] SETTLE_AUTO   = 12'h0_7D0;
  localparam logic [11:0] SETTLE_MANUAL = 12'h0_5DC;

  localparam int TABLE_DEPTH = 64;
  localparam logic [7:0] SKIP_VALUE = 8'h0_0FF;
  localparam logic [7:0] CHANNEL_RESET = 8'h0_000;

  // Register byte offsets
  localparam logic [7:0] REG_INTE      = 8'h0_000;
  localparam logic [7:0] REG_FRAC      = 8'h0_004;
  localparam logic [7:0] REG_STEP      = 8'h0_008;
  localparam logic [7:0] REG_HOPCTL    = 8'h0_00C;
  localparam logic [7:0] REG_THRESH    = 8'h0_010;
  localparam logic [7:0] REG_CMD       = 8'h0_014;
  localparam logic [7:0] REG_VCOCNT    = 8'h0_018;
  localparam logic [7:0] REG_STATUS    = 8'h0_01C;
  localparam logic [7:0] REG_FREQ      = 8'h0_020;
  localparam logic [7:0] REG_TABLE     = 8'h0_080;

  // Hop control fields
  localparam int HC_AUTO   = 0;
  localparam int HC_RSSI   = 1;
  localparam int HC_PRE    = 2;
  localparam int HC_SYNC   = 3;
  localparam int HC_PKT    = 4;
  localparam int HC_GPIO   = 5;

  // Command codes in REG_CMD[15:8]; channel in [7:0]; bit 16 says channel given
  localparam logic [7:0] CMD_START_RX = 8'h0_032;
  localparam logic [7:0] CMD_START_TX = 8'h0_031;
  localparam logic [7:0] CMD_RX_HOP   = 8'h0_036;
  localparam logic [7:0] CMD_IDLE     = 8'h0_003;

  typedef enum logic [1:0] {
    RXHOP_IDLE = 2'b00,
    RXHOP_TX   = 2'b01,
    RXHOP_RX   = 2'b10,
    RXHOP_TUNE = 2'b11
  } rxhop_state_t;

  typedef struct packed {
    logic [7:0]  inte;
    logic [19:0] frac;
    logic [15:0] step;
  } rxhop_synth_t;

  typedef struct packed {
    logic [7:0] rssi;
    logic       preambleTimeout;
    logic       syncTimeout;
    logic       preambleValid;
    logic       syncDetect;
  } rxhop_modem_t;

  function automatic logic is_skip(input logic [7:0] entry);
    return entry == SKIP_VALUE;
  endfunction

endpackage

// ---- verilog/rxhop_freq_calc.sv ----
`timescale 1ns/10ps
`default_nettype none
// Synthesizer word: base plus channel times step, in fraction units
module rxhop_freq_calc
  import rxhop_pkg::*;
(
  // Clock
  input  wire logic         sys_clk,
  // Settings
  input  wire rxhop_synth_t synth,
  input  wire logic [7:0]   channel,
  // Result: integer in [27:20], fraction in [19:0] over 2^19 scale
  output logic [35:0]       freqWord
);
  logic [27:0] baseWord;
  logic [23:0] offset;
  assign baseWord = {synth.inte, synth.frac} ;
  assign offset   = channel * synth.step;
  always_ff @(posedge sys_clk) begin
    freqWord <= {8'h0_000, baseWord} + {12'h0_000, offset};
  end
endmodule // rxhop_freq_calc
`default_nettype wire

// ---- verilog/rxhop_table_scan.sv ----
`timescale 1ns/10ps
`default_nettype none
// Finds next non-skip entry after a position, wrapping at size
module rxhop_table_scan
  import rxhop_pkg::*;
(
  // Table contents flattened
  input  wire logic [TABLE_DEPTH*8-1:0] entries,
  input  wire logic [6:0]               size,
  input  wire logic [5:0]               current,
  // Result
  output logic [5:0]                    nextIndex,
  output logic                          found,
  output logic                          wrapped
);
  always_comb begin
    int k;
    logic [6:0] pos;
    logic [7:0] e;
    k = 0;
    pos = 7'(current);
    e = 8'h0_000;
    nextIndex = current;
    found = 1'b0;
    wrapped = 1'b0;
    for (k = 0; k < TABLE_DEPTH; k++) begin
      if (!found && size != 7'h0_000) begin
        pos = pos + 7'h0_001;
        if (pos >= size) begin
          pos = 7'h0_000;
          wrapped = 1'b1;
        end
        e = entries[pos[5:0]*8 +: 8];
        if (!is_skip(e)) begin
          found = 1'b1;
          nextIndex = pos[5:0];
        end
      end
    end
    if (!found) begin
      wrapped = 1'b0;
    end
  end
endmodule // rxhop_table_scan
`default_nettype wire

// ---- verilog/rxhop_controller.sv ----
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Channel selection and automatic receive hopping
module rxhop_controller
  import rxhop_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // Wishbone slave
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [7:0]   adr_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [31:0]  dat_i,
  output logic [31:0]       dat_o,
  output logic              ack_o,
  // Modem status
  input  wire rxhop_modem_t modem,
  // Synthesizer side
  output logic [35:0]       synthWord,
  output logic              synthLoad,
  output logic [7:0]        calCount,
  output logic              rxActive,
  output logic              txActive,
  output logic              hopPin
);
  rxhop_synth_t        synth;
  logic [7:0]          channel;
  logic [7:0]          hopCtl;
  logic [6:0]          tableSize;
  logic [7:0]          threshold;
  logic [7:0]          hopTable [TABLE_DEPTH];
  logic [TABLE_DEPTH*8-1:0] flat;
  logic [5:0]          hopIndex;
  logic                locked;
  rxhop_state_t        state;
  logic [11:0]         settle;
  logic                txPending;
  logic [35:0]         freqWord;
  logic [5:0]          nextIndex;
  logic                found;
  logic                wrapped;

  // Bus decode
  wire logic access  = cyc_i && stb_i && !ack_o;
  wire logic wr      = access && we_i;
  wire logic isTable = adr_i[7];
  // Table slot of a byte address in the upper half
  function automatic logic [5:0] table_slot(input logic [7:0] addr);
    return {1'b0, addr[6:2]};
  endfunction
  wire logic [31:0] wData = {sel_i[3] ? dat_i[31:24] : 8'h0_000,
                             sel_i[2] ? dat_i[23:16] : 8'h0_000,
                             sel_i[1] ? dat_i[15:8]  : 8'h0_000,
                             sel_i[0] ? dat_i[7:0]   : 8'h0_000};
  wire logic cmdWr   = wr && adr_i == REG_CMD;
  wire logic [7:0] cmdCode = dat_i[15:8];
  wire logic cmdHasCh = dat_i[16];

  // Hop decision
  wire logic pktMode  = hopCtl[HC_PKT];
  wire logic rssiHop  = hopCtl[HC_RSSI] && modem.rssi < threshold;
  wire logic rssiStay = hopCtl[HC_RSSI] && modem.rssi > threshold;
  wire logic preHop   = pktMode && hopCtl[HC_PRE] && modem.preambleTimeout;
  wire logic syncHop  = pktMode && hopCtl[HC_SYNC] && modem.syncTimeout;
  wire logic pktStay  = pktMode && (hopCtl[HC_PRE] || hopCtl[HC_SYNC])
                        && modem.syncDetect;
  wire logic doHop    = hopCtl[HC_AUTO] && !locked && (rssiHop || preHop || syncHop);
  wire logic doStay   = !locked && (rssiStay || pktStay);

  genvar g;
  generate
    for (g = 0; g < TABLE_DEPTH; g++) begin : gFlat
      assign flat[g*8 +: 8] = hopTable[g];
    end
  endgenerate

  rxhop_table_scan uScan (
    .entries   (flat),
    .size      (tableSize),
    .current   (hopIndex),
    .nextIndex (nextIndex),
    .found     (found),
    .wrapped   (wrapped)
  );

  rxhop_freq_calc uFreq (
    .sys_clk  (sys_clk),
    .synth    (synth),
    .channel  (channel),
    .freqWord (freqWord)
  );

  // Register writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      synth     <= '0;
      hopCtl    <= 8'h0_000;
      tableSize <= 7'h0_000;
      threshold <= 8'h0_000;
      calCount  <= 8'h0_000;
    end else if (wr) begin
      if (adr_i == REG_INTE) begin
        synth.inte <= wData[7:0];
      end else if (adr_i == REG_FRAC) begin
        synth.frac <= wData[19:0];
      end else if (adr_i == REG_STEP) begin
        synth.step <= wData[15:0];
      end else if (adr_i == REG_HOPCTL) begin
        hopCtl    <= wData[7:0];
        tableSize <= wData[14:8] > 7'h0_040 ? 7'h0_040 : wData[14:8];
      end else if (adr_i == REG_THRESH) begin
        threshold <= wData[7:0];
      end else if (adr_i == REG_VCOCNT) begin
        calCount  <= wData[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr && isTable) begin
      hopTable[table_slot(adr_i)] <= wData[7:0];
    end
  end

  // Channel and receive sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      channel   <= CHANNEL_RESET;
      state     <= RXHOP_IDLE;
      settle    <= 12'h0_000;
      hopIndex  <= 6'h0_000;
      locked    <= 1'b0;
      txPending <= 1'b0;
      synthLoad <= 1'b0;
      hopPin    <= 1'b0;
    end else begin
      synthLoad <= 1'b0;
      if (cmdWr && (cmdCode == CMD_START_RX || cmdCode == CMD_START_TX)) begin
        if (cmdHasCh) begin
          channel <= dat_i[7:0];
        end
        hopIndex <= 6'h0_000;
        locked   <= 1'b0;
        settle   <= SETTLE_AUTO;
        synthLoad <= 1'b1;
        // Transmit also waits for the synthesizer to settle
        txPending <= cmdCode == CMD_START_TX;
        state    <= RXHOP_TUNE;
      end else if (cmdWr && cmdCode == CMD_RX_HOP) begin
        channel   <= dat_i[7:0];
        settle    <= SETTLE_MANUAL;
        txPending <= 1'b0;
        synthLoad <= 1'b1;
        state     <= RXHOP_TUNE;
      end else if (cmdWr && cmdCode == CMD_IDLE) begin
        state <= RXHOP_IDLE;
      end else begin
        case (state)
          RXHOP_TUNE: begin
            if (settle == 12'h0_000) begin
              state <= txPending ? RXHOP_TX : RXHOP_RX;
            end else begin
              settle <= settle - 12'h0_001;
            end
          end
          RXHOP_RX: begin
            if (doStay) begin
              locked <= 1'b1;
            end else if (doHop && found && nextIndex != hopIndex) begin
              hopIndex  <= nextIndex;
              channel   <= hopTable[nextIndex];
              settle    <= SETTLE_AUTO;
              synthLoad <= 1'b1;
              state     <= RXHOP_TUNE;
              if (hopCtl[HC_GPIO]) begin
                hopPin <= ~hopPin ^ wrapped;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Outputs and read data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_o     <= 1'b0;
      dat_o     <= 32'h0000_0000;
      synthWord <= 36'h0_0000_0000;
      rxActive  <= 1'b0;
      txActive  <= 1'b0;
    end else begin
      ack_o     <= access;
      synthWord <= freqWord;
      rxActive  <= state == RXHOP_RX;
      txActive  <= state == RXHOP_TX;
      if (access && !we_i) begin
        if (adr_i == REG_INTE) begin
          dat_o <= {24'h00_0000, synth.inte};
        end else if (adr_i == REG_FRAC) begin
          dat_o <= {12'h0_000, synth.frac};
        end else if (adr_i == REG_STEP) begin
          dat_o <= {16'h0000, synth.step};
        end else if (adr_i == REG_HOPCTL) begin
          dat_o <= {17'h0_0000, tableSize, hopCtl};
        end else if (adr_i == REG_THRESH) begin
          dat_o <= {24'h00_0000, threshold};
        end else if (adr_i == REG_VCOCNT) begin
          dat_o <= {24'h00_0000, calCount};
        end else if (adr_i == REG_STATUS) begin
          dat_o <= {13'h0000, locked, state, 2'b00, hopIndex, channel};
        end else if (adr_i == REG_FREQ) begin
          dat_o <= freqWord[31:0];
        end else if (isTable) begin
          dat_o <= {24'h00_0000, hopTable[table_slot(adr_i)]};
        end else begin
          dat_o <= 32'h0000_0000;
        end
      end
    end
  end
endmodule // rxhop_controller
`default_nettype wire

// ---- tb/rxhop_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module rxhop_sva
  import rxhop_pkg::*;
(
  // Clock and bus
  input wire logic         sys_clk,
  input wire logic         srst,
  input wire logic         cyc_i,
  input wire logic         stb_i,
  input wire logic         we_i,
  input wire logic [7:0]   adr_i,
  input wire logic [3:0]   sel_i,
  input wire logic [31:0]  dat_i,
  input wire logic [31:0]  dat_o,
  input wire logic         ack_o,
  // Radio side
  input wire rxhop_modem_t modem,
  input wire logic [35:0]  synthWord,
  input wire logic         synthLoad,
  input wire logic [7:0]   calCount,
  input wire logic         rxActive,
  input wire logic         txActive,
  input wire logic         hopPin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  int tuneCnt;
  // Cycles from a retune until active again
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tuneCnt <= 0;
    end else if (cyc_i && stb_i && we_i && !ack_o && adr_i == REG_CMD
                 && dat_i[15:8] == CMD_IDLE) begin
      tuneCnt <= 0;
    end else if (synthLoad) begin
      tuneCnt <= 1;
    end else if (tuneCnt > 8 && (rxActive || txActive)) begin
      tuneCnt <= 0;
    end else if (tuneCnt != 0) begin
      tuneCnt <= tuneCnt + 1;
    end
  end
  sequence busReq;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence tuneGap;
    (!rxActive && !txActive) [*8];
  endsequence
  AST_ACK_NEXT: assert property (busReq |=> ack_o)
    else $error("request not answered");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  AST_DAT_READ: assert property ($changed(dat_o) |-> $past(cyc_i && stb_i && !we_i))
    else $error("read data moved without read");
  AST_RST_QUIET: assert property (disable iff (1'b0) srst |=> !rxActive && !txActive && !hopPin)
    else $error("outputs active after reset");
  AST_ONE_MODE: assert property (!(rxActive && txActive))
    else $error("receive and transmit together");
  AST_LOAD_PULSE: assert property (synthLoad |=> !synthLoad)
    else $error("load held");
  AST_TUNE_GAP: assert property (synthLoad |-> ##2 tuneGap)
    else $error("active during retune");
  AST_TUNE_BOUND: assert property (tuneCnt <= AUTO_HOP_CYC)
    else $error("retune too slow");
  AST_WORD_LOAD: assert property ($changed(synthWord) |-> $past(synthLoad, 2) || $past(cyc_i && stb_i && we_i && !ack_o, 3))
    else $error("tuning word moved without load");
endmodule // rxhop_sva
bind rxhop_controller rxhop_sva u_sva (.sys_clk, .srst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .modem, .synthWord, .synthLoad, .calCount, .rxActive, .txActive,
  .hopPin);
`default_nettype wire

// ---- tb/rxhop_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module rxhop_host_model (
  // Clock and answer
  input wire logic        sys_clk,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  // Request
  output logic            cyc_i,
  output logic            stb_i,
  output logic            we_i,
  output logic [7:0]      adr_i,
  output logic [3:0]      sel_i,
  output logic [31:0]     dat_i
);
  initial begin
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = '0;
    sel_i = 4'hf;
    dat_i = '0;
  end
  // One classic cycle; ok stays low if no answer came
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(posedge sys_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= a;
    dat_i <= d;
    ok = 1'b0;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge sys_clk);
      ok = ack_o;
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    dat_i <= ~d;
  endtask
endmodule // rxhop_host_model
`default_nettype wire

// ---- tb/test_rx_channel_hop_controller.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_rx_channel_hop_controller
  import rxhop_pkg::*;
;
  logic         sys_clk = 1'b0;
  logic         srst = 1'b1;
  logic         cyc_i, stb_i, we_i, ack_o, synthLoad, rxActive, txActive, hopPin, p;
  logic [7:0]   adr_i;
  logic [7:0]   calCount;
  logic [3:0]   sel_i;
  logic [31:0]  dat_i;
  logic [31:0]  dat_o;
  logic [31:0]  rdata;
  logic [35:0]  synthWord;
  logic [35:0]  w0, w3, w6;
  rxhop_modem_t modem = '0;
  int           mismatches = 0;
  int           samples_checked = 0;
  always #20 sys_clk = ~sys_clk;
  rxhop_controller dut (.sys_clk, .srst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .modem, .synthWord, .synthLoad, .calCount, .rxActive, .txActive, .hopPin);
  rxhop_host_model host (.sys_clk, .ack_o, .dat_o, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i);
  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    host.xfer(we, a, d, rdata, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic cmd(input logic [7:0] code, input logic [7:0] ch, input logic has);
    bus(1'b1, REG_CMD, {15'h0000, has, code, ch});
  endtask
  // Wait for tuning to drop and regain an active state
  task automatic settle(input int lim);
    int n;
    logic low;
    low = 1'b0;
    for (n = 0; n < lim && !(low && (rxActive || txActive)); n++) begin
      @(posedge sys_clk);
      low = low | !(rxActive || txActive);
    end
    chk(low && (rxActive || txActive), 1'b1);
  endtask
  task automatic chan(input logic [7:0] ch);
    bus(1'b0, REG_STATUS, '0);
    chk(rdata[7:0], ch);
  endtask
  task automatic hop(input logic [7:0] cur, input logic [7:0] ch, input logic pin);
    int n;
    rdata = {24'h00_0000, cur};
    for (n = 0; n < 1500 && rdata[7:0] === cur; n++) begin
      bus(1'b0, REG_STATUS, '0);
    end
    chk(rdata[7:0], ch);
    chk(hopPin, pin);
  endtask
  task automatic stays(input logic [7:0] ch);
    repeat (6000) @(posedge sys_clk);
    chan(ch);
  endtask
  task automatic t_basic();
    chan(CHANNEL_RESET);
    bus(1'b1, 8'h40, 32'h1234_5678);
    bus(1'b0, 8'h40, '0);
    chk(rdata, '0);
    bus(1'b1, REG_INTE, 32'h0000_0041);
    bus(1'b1, REG_FRAC, 32'h0008_0000);
    bus(1'b1, REG_STEP, 32'h0000_1000);
    cmd(CMD_START_RX, 8'h09, 1'b0);
    settle(AUTO_HOP_CYC);
    chan(8'h00);
    w0 = synthWord;
    cmd(CMD_START_TX, 8'h06, 1'b1);
    settle(AUTO_HOP_CYC);
    chk(txActive, 1'b1);
    chan(8'h06);
    w6 = synthWord;
    cmd(CMD_START_RX, 8'h03, 1'b1);
    settle(AUTO_HOP_CYC);
    w3 = synthWord;
    chk(w0, 36'h0_0418_0000);
    chk(w3 - w0, 36'h0_0000_3000);
    chk(w6 - w0, (w3 - w0) * 2);
    chk(w3 === w0, 1'b0);
    cmd(CMD_START_RX, 8'h0c, 1'b0);
    chan(8'h03);
  endtask
  task automatic t_auto();
    bus(1'b1, REG_HOPCTL, 32'h0000_0400);
    bus(1'b1, REG_TABLE, 32'h0000_0002);
    bus(1'b1, REG_TABLE + 8'h04, 32'h0000_00ff);
    bus(1'b1, REG_TABLE + 8'h08, 32'h0000_0007);
    bus(1'b1, REG_TABLE + 8'h0c, 32'h0000_0009);
    bus(1'b1, REG_HOPCTL, 32'h0000_0423);
    bus(1'b1, REG_THRESH, 32'h0000_0040);
    modem.rssi <= 8'h10;
    p = hopPin;
    cmd(CMD_START_RX, 8'h02, 1'b1);
    settle(AUTO_HOP_CYC);
    hop(8'h02, 8'h07, ~p);
    settle(AUTO_HOP_CYC);
    hop(8'h07, 8'h09, p);
    settle(AUTO_HOP_CYC);
    hop(8'h09, 8'h02, p);
    modem.rssi <= 8'h80;
    stays(8'h02);
    chk(rxActive, 1'b1);
  endtask
  task automatic t_cond();
    int i;
    modem.rssi <= 8'h10;
    modem.preambleTimeout <= 1'b1;
    bus(1'b1, REG_HOPCTL, 32'h0000_0405);
    cmd(CMD_START_RX, 8'h07, 1'b1);
    stays(8'h07);
    bus(1'b1, REG_HOPCTL, 32'h0000_0415);
    cmd(CMD_START_RX, 8'h07, 1'b1);
    settle(AUTO_HOP_CYC);
    hop(8'h07, 8'h09, p);
    modem.preambleTimeout <= 1'b0;
    modem.syncTimeout <= 1'b1;
    bus(1'b1, REG_HOPCTL, 32'h0000_0419);
    hop(8'h09, 8'h02, p);
    modem.syncTimeout <= 1'b0;
    for (i = 0; i < 4; i++) begin
      bus(1'b1, REG_TABLE + 8'(4 * i), 32'h0000_00ff);
    end
    bus(1'b1, REG_HOPCTL, 32'h0000_0403);
    cmd(CMD_START_RX, 8'h05, 1'b1);
    stays(8'h05);
    bus(1'b1, REG_TABLE, 32'h0000_0001);
    bus(1'b1, REG_HOPCTL, 32'h0000_0402);
    cmd(CMD_START_RX, 8'h04, 1'b1);
    stays(8'h04);
  endtask
  task automatic t_manual();
    bus(1'b1, REG_VCOCNT, 32'h0000_005a);
    chk(calCount, 8'h5a);
    cmd(CMD_RX_HOP, 8'h0b, 1'b1);
    settle(MANUAL_HOP_CYC);
    chan(8'h0b);
    cmd(CMD_IDLE, 8'h00, 1'b0);
    bus(1'b0, REG_STATUS, '0);
    chk(rxActive || txActive, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    t_basic();
    t_auto();
    t_cond();
    t_manual();
    finish_test();
  end
endmodule // test_rx_channel_hop_controller
`default_nettype wire
